/* rtl/pldm_cfg.svh */
// Constants for the programmable decode and macrocell block
// ============================================================
// Notes on behaviour
// - Eight primary flash sector selects, each an OR of three product terms.
// - Four secondary flash sector selects, each an OR of three product terms.
// - One SRAM select built from three product terms.
// - One test-port select; when high it enables the serial test port.
// - One configuration-space select, ungated, and two peripheral selects gated by peripheral mode.
// - Separate-space bus mode feeds address bits 19 to 4 into the decode array.
// - Eight external chip selects, each routed to port C or port F.
// - External chip selects use their own terms, never an output cell.
// - 24 input cells and 16 output cells share one product-term array.
// - The shared array forms up to 196 product terms.
// - Host writes output cell flip-flops and reads back input and output cells.
// - Output cells 0-7 drive port A pins 0-7, 8-15 port B pins 0-7, in order.
// - Each output cell sum passes an XOR stage selecting true or inverted polarity.
// - A mux picks flip-flop or sum, driving the pin and the array feedback.
// - Each cell flip-flop acts as D, T, JK or SR type.
// - Flip-flop clock is a product term or the logic clock pin rising edge.
// - Preset and clear come from product terms and act when high.
// - Clear accepts a sum of at most two product terms.
// - Port A cells allow 9 sum terms, port B 0-3 allow 9, 4-7 allow 10.
// - Port A cell n uses data bit n, port B bit n+8; big-endian swaps lanes.
// - A host write loads the flip-flops at the trailing edge of the write strobe.
// - A host load overrides the flip-flop clock, preset and clear.
// - Per-port write mask resets to 00h; a one blocks loads to that cell.
`ifndef PLDM_CFG_SVH
`define PLDM_CFG_SVH
// ============================================================
// Array sizes
`define PLDM_NTERM 196
`define PLDM_NIN 48
`define PLDM_NDT 43
`define PLDM_NCELL 16
`define PLDM_NIMC 24
`define PLDM_NECS 8
`define PLDM_PT_MAX 8'hC4
`define PLDM_PT_NONE 8'hFF
// ============================================================
// Decode term layout
`define PLDM_DT_PRI 0
`define PLDM_DT_SEC 24
`define PLDM_DT_SRAM 36
`define PLDM_DT_CFG 39
`define PLDM_DT_TEST 40
`define PLDM_DT_PER 41
`define PLDM_DT_PER_SEL 3
`define PLDM_DBUS_PAD 19'h00000
// ============================================================
// Sum term limits and reset values
`define PLDM_LIM_A 9
`define PLDM_LIM_B_LO 9
`define PLDM_LIM_B_HI 10
`define PLDM_MASK_RST 8'h00
`define PLDM_CTL_SYNC_RST 2'h1
`endif

/* rtl/pldm_pkg.sv */
// Types and term evaluation shared by the programmable logic block
`default_nettype none
`include "pldm_cfg.svh"
package pldm_pkg;
	// ============================================================
	// Enumerations
	typedef enum logic [1:0] {FF_D = 2'b00, FF_T = 2'b01, FF_JK = 2'b10, FF_SR = 2'b11} pldm_ff_t;
	typedef enum logic [1:0] {TGT_OMC = 2'b00, TGT_MASK_A = 2'b01, TGT_MASK_B = 2'b10, TGT_NONE = 2'b11} pldm_tgt_t;
	typedef enum logic [1:0] {RD_OMC = 2'b00, RD_IMC_AB = 2'b01, RD_IMC_C = 2'b10, RD_MASK = 2'b11} pldm_rd_t;
	// ============================================================
	// State records
	typedef struct packed {
		logic [7:0] pri;
		logic [3:0] sec;
		logic sram;
		logic cfg;
		logic test;
		logic [1:0] per;
	} pldm_dec_st_t;
	typedef struct packed {
		logic wr_lvl_d;
		logic lclk_d;
		logic [15:0] cap_data;
		pldm_tgt_t cap_tgt;
		logic [15:0] pt_prev;
		logic [15:0] ff_q;
		logic [15:0] cell_out;
		logic [7:0] mask_a;
		logic [7:0] mask_b;
		logic [15:0] rd_data;
		logic [7:0] ecs_c;
		logic [7:0] ecs_f;
	} pldm_top_st_t;
	// ============================================================
	// Product term: an empty term reads low, as an unused term would
	function automatic logic pt_and(input logic [`PLDM_NIN-1:0] v, input logic [`PLDM_NIN-1:0] t,
		input logic [`PLDM_NIN-1:0] c);
		if ((t | c) == '0) begin
			return 1'b0;
		end
		return (&(v | ~t)) & (&(~v | ~c));
	endfunction
	// Pick one shared term; an out-of-range index means no term
	function automatic logic pt_pick(input logic [`PLDM_NTERM-1:0] terms, input logic [7:0] idx);
		if (idx < `PLDM_PT_MAX) begin
			return terms[idx];
		end
		return 1'b0;
	endfunction
endpackage
`default_nettype wire

/* rtl/pldm_dec_if.sv */
// Select signals from the decode array to the top level
`timescale 1ns/100ps
`default_nettype none
interface pldm_dec_if;
	logic [7:0] primary_sector_sel;
	logic [3:0] secondary_sector_sel;
	logic sram_sel;
	logic config_space_sel;
	logic test_sel;
	logic [1:0] periph_sel;
	modport src(output primary_sector_sel, secondary_sector_sel, sram_sel, config_space_sel, test_sel, periph_sel);
	modport dst(input primary_sector_sel, secondary_sector_sel, sram_sel, config_space_sel, test_sel, periph_sel);
endinterface
`default_nettype wire

/* rtl/pldm_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pldm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Pin side and filtered level
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] lvl_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} pldm_sync_st_t;
	pldm_sync_st_t st, nx;
	// A bit changes only once stages two and three agree, so one metastable sample never counts
	always_comb begin
		nx = st;
		nx.s1 = d_in;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.lvl = ((st.s2 ~^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.lvl);
	end
	// State register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st <= nx;
		end
	end
	assign lvl_out = st.lvl;
	// Filtered level moves only toward an agreed value
	agree_only_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(st.lvl != $past(st.lvl)) |-> (st.lvl == $past(st.s3)))
		else $error("synchroniser level changed without agreement");
endmodule
`default_nettype wire

/* rtl/pldm_decode.sv */
// Address decode array producing memory and space selects
`timescale 1ns/100ps
`default_nettype none
`include "pldm_cfg.svh"
module pldm_decode (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Internal bus inputs
	input wire logic [19:0] bus_addr_in,
	input wire logic [2:0] bus_ctl_in,
	input wire logic [7:0] page_reg_in,
	input wire logic flash_ready_in,
	input wire logic power_down_in,
	// Static modes
	input wire logic sep_space_mode_in,
	input wire logic periph_mode_in,
	// Static term configuration
	input wire logic [`PLDM_NDT-1:0][`PLDM_NIN-1:0] dec_true_in,
	input wire logic [`PLDM_NDT-1:0][`PLDM_NIN-1:0] dec_comp_in,
	// Selects
	pldm_dec_if.src dec
);
	import pldm_pkg::*;
	logic [15:0] addr;
	logic [`PLDM_NIN-1:0] dbus;
	logic [`PLDM_NDT-1:0] dt;
	pldm_dec_st_t st, nx;
	// Address window follows the bus mode
	assign addr = sep_space_mode_in ? bus_addr_in[19:4] : bus_addr_in[15:0];
	assign dbus = {`PLDM_DBUS_PAD, flash_ready_in, power_down_in, page_reg_in, bus_ctl_in, addr};
	// ============================================================
	// Decode product terms
	for (genvar g = 0; g < `PLDM_NDT; g++) begin : g_dt
		assign dt[g] = pt_and(dbus, dec_true_in[g], dec_comp_in[g]);
	end
	// Sums of three terms for the memory selects
	always_comb begin
		nx = st;
		for (int i = 0; i < 8; i++) begin
			nx.pri[i] = |dt[`PLDM_DT_PRI + i * `PLDM_DT_PER_SEL +: `PLDM_DT_PER_SEL];
		end
		for (int i = 0; i < 4; i++) begin
			nx.sec[i] = |dt[`PLDM_DT_SEC + i * `PLDM_DT_PER_SEL +: `PLDM_DT_PER_SEL];
		end
		nx.sram = |dt[`PLDM_DT_SRAM +: `PLDM_DT_PER_SEL];
		nx.cfg = dt[`PLDM_DT_CFG];
		nx.test = dt[`PLDM_DT_TEST];
		nx.per = periph_mode_in ? dt[`PLDM_DT_PER +: 2] : 2'h0;
	end
	// State register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end
	assign dec.primary_sector_sel = st.pri;
	assign dec.secondary_sector_sel = st.sec;
	assign dec.sram_sel = st.sram;
	assign dec.config_space_sel = st.cfg;
	assign dec.test_sel = st.test;
	assign dec.periph_sel = st.per;
	// ============================================================
	// Checks
	primary_three_terms_a: assert property (@(posedge clk_in) disable iff (rst_in)
		##1 (st.pri[0] == $past(|dt[2:0])))
		else $error("primary select 0 does not follow its three terms");
	periph_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!periph_mode_in |=> (st.per == 2'h0))
		else $error("peripheral select active outside peripheral mode");
	sep_space_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
		sep_space_mode_in |-> (dbus[15:0] == bus_addr_in[19:4]))
		else $error("separate-space mode does not use upper address bits");
endmodule
`default_nettype wire

/* rtl/pldm_top.sv */
// Decode array, general logic array and 16 output cells with host load and readback
`timescale 1ns/100ps
`default_nettype none
`include "pldm_cfg.svh"
module pldm_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Host write strobe pin and bus latch
	input wire logic host_wr_n_in,
	input wire logic [15:0] host_data_in,
	input wire pldm_pkg::pldm_tgt_t host_target_in,
	input wire pldm_pkg::pldm_rd_t host_rd_sel_in,
	input wire logic big_endian_in,
	output logic [15:0] host_rd_data_out,
	// Decode inputs
	input wire logic [19:0] bus_addr_in,
	input wire logic [2:0] bus_ctl_in,
	input wire logic [7:0] page_reg_in,
	input wire logic flash_ready_in,
	input wire logic power_down_in,
	input wire logic sep_space_mode_in,
	input wire logic periph_mode_in,
	input wire logic [`PLDM_NDT-1:0][`PLDM_NIN-1:0] dec_true_in,
	input wire logic [`PLDM_NDT-1:0][`PLDM_NIN-1:0] dec_comp_in,
	// Decode selects
	output logic [7:0] primary_sector_sel_out,
	output logic [3:0] secondary_sector_sel_out,
	output logic sram_sel_out,
	output logic config_space_sel_out,
	output logic test_port_en_out,
	output logic [1:0] periph_sel_out,
	// Port pins and logic clock pin
	input wire logic [7:0] port_a_pin_in,
	input wire logic [7:0] port_b_pin_in,
	input wire logic [7:0] port_c_pin_in,
	input wire logic logic_clock_in,
	// General array terms
	input wire logic [`PLDM_NTERM-1:0][`PLDM_NIN-1:0] gen_true_in,
	input wire logic [`PLDM_NTERM-1:0][`PLDM_NIN-1:0] gen_comp_in,
	// Output cell configuration
	input wire logic [`PLDM_NCELL-1:0][`PLDM_NTERM-1:0] cell_sum_sel_in,
	input wire pldm_pkg::pldm_ff_t [`PLDM_NCELL-1:0] cell_type_in,
	input wire logic [`PLDM_NCELL-1:0] cell_inv_in,
	input wire logic [`PLDM_NCELL-1:0] cell_reg_sel_in,
	input wire logic [`PLDM_NCELL-1:0] cell_clk_pin_in,
	input wire logic [`PLDM_NCELL-1:0][7:0] cell_k_idx_in,
	input wire logic [`PLDM_NCELL-1:0][7:0] cell_clk_idx_in,
	input wire logic [`PLDM_NCELL-1:0][7:0] cell_pre_idx_in,
	input wire logic [`PLDM_NCELL-1:0][1:0][7:0] cell_clr_idx_in,
	// External chip select configuration
	input wire logic [`PLDM_NECS-1:0][7:0] ecs_idx_in,
	input wire logic [`PLDM_NECS-1:0] ecs_low_in,
	input wire logic [`PLDM_NECS-1:0] ecs_to_f_in,
	// Cell and chip select outputs
	output logic [7:0] port_a_out_cell_out,
	output logic [7:0] port_b_out_cell_out,
	output logic [7:0] ext_chip_sel_c_out,
	output logic [7:0] ext_chip_sel_f_out
);
	import pldm_pkg::*;
	// ============================================================
	// Declarations
	pldm_top_st_t st, nx;
	pldm_dec_if dif();
	logic [`PLDM_NIMC-1:0] input_cell;
	logic [1:0] ctl_lvl;
	logic wr_lvl;
	logic lclk_rise;
	logic load_pls;
	logic mask_pls_a;
	logic mask_pls_b;
	logic [15:0] ld;
	logic [15:0] mask;
	logic [`PLDM_NIN-1:0] gbus;
	logic [`PLDM_NTERM-1:0] terms;
	// Byte-lane order for host data; the swap is its own inverse
	function automatic logic [15:0] lanes(input logic [15:0] d, input logic be);
		return be ? {d[7:0], d[15:8]} : d;
	endfunction
	// ============================================================
	// Pin synchronisers
	pldm_sync #(.W(`PLDM_NIMC), .RST_VAL('0)) u_imc_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in({port_c_pin_in, port_b_pin_in, port_a_pin_in}),
		.lvl_out(input_cell)
	);
	// Strobe idles high after reset so its release is not seen as a write
	pldm_sync #(.W(2), .RST_VAL(`PLDM_CTL_SYNC_RST)) u_ctl_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.d_in({logic_clock_in, host_wr_n_in}),
		.lvl_out(ctl_lvl)
	);
	assign wr_lvl = ctl_lvl[0];
	assign lclk_rise = ctl_lvl[1] & !st.lclk_d;
	// ============================================================
	// Decode array
	pldm_decode u_decode (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.bus_addr_in(bus_addr_in),
		.bus_ctl_in(bus_ctl_in),
		.page_reg_in(page_reg_in),
		.flash_ready_in(flash_ready_in),
		.power_down_in(power_down_in),
		.sep_space_mode_in(sep_space_mode_in),
		.periph_mode_in(periph_mode_in),
		.dec_true_in(dec_true_in),
		.dec_comp_in(dec_comp_in),
		.dec(dif)
	);
	assign primary_sector_sel_out = dif.primary_sector_sel;
	assign secondary_sector_sel_out = dif.secondary_sector_sel;
	assign sram_sel_out = dif.sram_sel;
	assign config_space_sel_out = dif.config_space_sel;
	assign test_port_en_out = dif.test_sel;
	assign periph_sel_out = dif.periph_sel;
	// ============================================================
	// Shared product-term array: input cells, cell feedback, page bits
	assign gbus = {page_reg_in, st.cell_out, input_cell};
	for (genvar g = 0; g < `PLDM_NTERM; g++) begin : g_pt
		assign terms[g] = pt_and(gbus, gen_true_in[g], gen_comp_in[g]);
	end
	// ============================================================
	// Host write decode: act on the strobe's trailing edge only
	assign load_pls = wr_lvl && !st.wr_lvl_d && (st.cap_tgt == TGT_OMC);
	assign mask_pls_a = wr_lvl && !st.wr_lvl_d && (st.cap_tgt == TGT_MASK_A);
	assign mask_pls_b = wr_lvl && !st.wr_lvl_d && (st.cap_tgt == TGT_MASK_B);
	assign ld = lanes(st.cap_data, big_endian_in);
	assign mask = {st.mask_b, st.mask_a};
	// Next state: capture, masks, cells, chip selects, readback
	always_comb begin
		logic s;
		logic k;
		logic q;
		logic tick;
		logic pre;
		logic clr;
		logic cpt;
		logic v;
		s = 1'b0;
		k = 1'b0;
		q = 1'b0;
		tick = 1'b0;
		pre = 1'b0;
		clr = 1'b0;
		cpt = 1'b0;
		v = 1'b0;
		nx = st;
		nx.wr_lvl_d = wr_lvl;
		nx.lclk_d = ctl_lvl[1];
		// Data is held stable by the host while the strobe is low
		if (!wr_lvl) begin
			nx.cap_data = host_data_in;
			nx.cap_tgt = host_target_in;
		end
		if (mask_pls_a) begin
			nx.mask_a = ld[7:0];
		end
		if (mask_pls_b) begin
			nx.mask_b = ld[15:8];
		end
		// Output cells; configuration inputs are expected static
		for (int i = 0; i < `PLDM_NCELL; i++) begin
			s = (|(terms & cell_sum_sel_in[i])) ^ cell_inv_in[i];
			k = pt_pick(terms, cell_k_idx_in[i]);
			cpt = pt_pick(terms, cell_clk_idx_in[i]);
			nx.pt_prev[i] = cpt;
			tick = cell_clk_pin_in[i] ? lclk_rise : (cpt & !st.pt_prev[i]);
			pre = pt_pick(terms, cell_pre_idx_in[i]);
			clr = pt_pick(terms, cell_clr_idx_in[i][0]) | pt_pick(terms, cell_clr_idx_in[i][1]);
			q = st.ff_q[i];
			if (tick) begin
				case (cell_type_in[i])
					FF_D: q = s;
					FF_T: q = q ^ s;
					FF_JK: q = (s & k) ? !q : (s ? 1'b1 : (k ? 1'b0 : q));
					FF_SR: q = s ? 1'b1 : (k ? 1'b0 : q);
					default: q = s;
				endcase
			end
			if (pre) begin
				q = 1'b1;
			end
			if (clr) begin
				q = 1'b0;
			end
			// Host load wins over clock, preset and clear unless masked
			if (load_pls && !mask[i]) begin
				q = ld[i];
			end
			nx.ff_q[i] = q;
			nx.cell_out[i] = cell_reg_sel_in[i] ? q : s;
		end
		// Chip selects own one term each, no output cell consumed
		for (int j = 0; j < `PLDM_NECS; j++) begin
			v = pt_pick(terms, ecs_idx_in[j]) ^ ecs_low_in[j];
			nx.ecs_f[j] = ecs_to_f_in[j] ? v : ecs_low_in[j];
			nx.ecs_c[j] = ecs_to_f_in[j] ? ecs_low_in[j] : v;
		end
		// Readback of cells and masks in the chosen lane order
		case (host_rd_sel_in)
			RD_OMC: nx.rd_data = lanes(st.ff_q, big_endian_in);
			RD_IMC_AB: nx.rd_data = lanes(input_cell[15:0], big_endian_in);
			RD_IMC_C: nx.rd_data = lanes({8'h00, input_cell[23:16]}, big_endian_in);
			RD_MASK: nx.rd_data = lanes(mask, big_endian_in);
			default: nx.rd_data = 16'h0000;
		endcase
	end
	// State register; masks reset to their open value
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			st <= '0;
			st.wr_lvl_d <= 1'b1;
			st.cap_tgt <= TGT_NONE;
			st.mask_a <= `PLDM_MASK_RST;
			st.mask_b <= `PLDM_MASK_RST;
		end else begin
			st <= nx;
		end
	end
	// ============================================================
	// Outputs: cell n drives port A pin n, cell n+8 drives port B pin n
	assign port_a_out_cell_out = st.cell_out[7:0];
	assign port_b_out_cell_out = st.cell_out[15:8];
	assign ext_chip_sel_c_out = st.ecs_c;
	assign ext_chip_sel_f_out = st.ecs_f;
	assign host_rd_data_out = st.rd_data;
	// ============================================================
	// Checks
	load_take_a: assert property (@(posedge clk_in) disable iff (rst_in)
		load_pls |=> ((st.ff_q & ~$past(mask)) == ($past(ld) & ~$past(mask))))
		else $error("unmasked cells did not take the host data");
	mask_block_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(load_pls && mask[0] && cell_clk_pin_in[0] && !lclk_rise
		&& !pt_pick(terms, cell_pre_idx_in[0]) && !pt_pick(terms, cell_clr_idx_in[0][0])
		&& !pt_pick(terms, cell_clr_idx_in[0][1])) |=> $stable(st.ff_q[0]))
		else $error("masked cell changed on a host load");
	mask_reset_a: assert property (@(posedge clk_in) disable iff (rst_in)
		$fell(rst_in) |-> (mask == 16'h0000))
		else $error("write masks not clear after reset");
	lane_swap_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(host_rd_sel_in == RD_OMC && big_endian_in)
		|=> (st.rd_data == {$past(st.ff_q[7:0]), $past(st.ff_q[15:8])}))
		else $error("big-endian readback lanes wrong");
	pin_clock_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(lclk_rise && cell_clk_pin_in[0] && cell_type_in[0] == FF_D && !(load_pls && !mask[0])
		&& !pt_pick(terms, cell_pre_idx_in[0]) && !pt_pick(terms, cell_clr_idx_in[0][0])
		&& !pt_pick(terms, cell_clr_idx_in[0][1]))
		|=> (st.ff_q[0] == $past((|(terms & cell_sum_sel_in[0])) ^ cell_inv_in[0])))
		else $error("pin-clocked D cell did not capture its sum");
	clear_wins_a: assert property (@(posedge clk_in) disable iff (rst_in)
		(pt_pick(terms, cell_clr_idx_in[1][1]) && !(load_pls && !mask[1])) |=> !st.ff_q[1])
		else $error("clear term did not clear the cell");
	polarity_comb_a: assert property (@(posedge clk_in) disable iff (rst_in)
		!cell_reg_sel_in[0] |=> (st.cell_out[0] == $past((|(terms & cell_sum_sel_in[0])) ^ cell_inv_in[0])))
		else $error("combinational cell output has wrong polarity");
	sum_limit_a: assert property (@(posedge clk_in) disable iff (rst_in)
		($countones(cell_sum_sel_in[0]) <= `PLDM_LIM_A) && ($countones(cell_sum_sel_in[8]) <= `PLDM_LIM_B_LO)
		&& ($countones(cell_sum_sel_in[12]) <= `PLDM_LIM_B_HI))
		else $error("cell sum uses more terms than it may allocate");
	ecs_route_a: assert property (@(posedge clk_in) disable iff (rst_in)
		ecs_to_f_in[1] |=> (st.ecs_c[1] == $past(ecs_low_in[1])))
		else $error("chip select routed to port F still active on port C");
endmodule
`default_nettype wire

/* tb/pldm_host_model.sv */
// Host microcontroller model driving the write strobe, data lanes and readback select
`timescale 1ns/100ps
`default_nettype none
module pldm_host_model (
	// Clock
	input wire logic clk_in,
	// Host bus
	output logic host_wr_n_out,
	output logic [15:0] host_data_out,
	output var pldm_pkg::pldm_tgt_t host_target_out,
	output var pldm_pkg::pldm_rd_t host_rd_sel_out,
	input wire logic [15:0] host_rd_data_in
);
	import pldm_pkg::*;
	// ============================================================
	// Idle bus: strobe high, data lanes not holding a real value
	initial begin
		host_wr_n_out = 1'b1;
		host_data_out = 16'hFFFF;
		host_target_out = TGT_NONE;
		host_rd_sel_out = RD_OMC;
	end
	// Strobe low 4 cycles, high 6; data only moves once the filtered strobe is high
	task automatic wr(input logic [15:0] d, input pldm_tgt_t t);
		@(posedge clk_in);
		host_wr_n_out <= 1'b0;
		host_data_out <= d;
		host_target_out <= t;
		repeat (4) @(posedge clk_in);
		host_wr_n_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		host_data_out <= ~d;
		host_target_out <= TGT_NONE;
		repeat (2) @(posedge clk_in);
		// Return between edges so callers compare settled outputs
		@(negedge clk_in);
	endtask
	// Readback is registered one edge after the select
	task automatic rd(input pldm_rd_t s, output logic [15:0] q);
		@(posedge clk_in);
		host_rd_sel_out <= s;
		@(posedge clk_in);
		@(negedge clk_in);
		q = host_rd_data_in;
	endtask
endmodule
`default_nettype wire

/* tb/pldm_top_tb.sv */
// Self-checking bench for the decode array and output cells
`timescale 1ns/100ps
`default_nettype none
`include "pldm_cfg.svh"
module pldm_top_tb;
	import pldm_pkg::*;
	// ============================================================
	// Signals and static configuration
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic wr_n, be, sep, pm, lclk, fr, pd;
	logic [15:0] dat, rdd, q;
	pldm_tgt_t tgt;
	pldm_rd_t rsel;
	logic [19:0] addr;
	logic [2:0] ctl;
	logic [7:0] page, pa_i, pb_i, pc_i, pri, pa, pb, ec, ef_o;
	logic [3:0] sec;
	logic [1:0] per;
	logic sram, cfg, tst;
	logic [`PLDM_NDT-1:0][`PLDM_NIN-1:0] dt, dc;
	logic [`PLDM_NTERM-1:0][`PLDM_NIN-1:0] gt, gc;
	logic [`PLDM_NCELL-1:0][`PLDM_NTERM-1:0] ss;
	pldm_ff_t [`PLDM_NCELL-1:0] ty;
	logic [15:0] inv, regs, cpin;
	logic [15:0][7:0] kidx, cidx, pidx;
	logic [15:0][1:0][7:0] clr;
	logic [7:0][7:0] eidx;
	logic [7:0] elow, ef;
	logic [19:0] ad [4] = '{20'h0F800, 20'h0F800, 20'h0F800, 20'hF8000};
	logic [19:0] ex [4] = '{20'h0023D, 20'h0023C, 20'h00005, 20'h0023D};
	int fail_count = 0;
	int samples_checked = 0;
	// ============================================================
	// Clock, design and host
	always #25 clk_in = ~clk_in;
	pldm_top u_dut (.clk_in(clk_in), .rst_in(rst_in), .host_wr_n_in(wr_n), .host_data_in(dat),
		.host_target_in(tgt), .host_rd_sel_in(rsel), .big_endian_in(be), .host_rd_data_out(rdd),
		.bus_addr_in(addr), .bus_ctl_in(ctl), .page_reg_in(page), .flash_ready_in(fr), .power_down_in(pd),
		.sep_space_mode_in(sep), .periph_mode_in(pm), .dec_true_in(dt), .dec_comp_in(dc),
		.primary_sector_sel_out(pri), .secondary_sector_sel_out(sec), .sram_sel_out(sram),
		.config_space_sel_out(cfg), .test_port_en_out(tst), .periph_sel_out(per), .port_a_pin_in(pa_i),
		.port_b_pin_in(pb_i), .port_c_pin_in(pc_i), .logic_clock_in(lclk), .gen_true_in(gt), .gen_comp_in(gc),
		.cell_sum_sel_in(ss), .cell_type_in(ty), .cell_inv_in(inv), .cell_reg_sel_in(regs),
		.cell_clk_pin_in(cpin), .cell_k_idx_in(kidx), .cell_clk_idx_in(cidx), .cell_pre_idx_in(pidx),
		.cell_clr_idx_in(clr), .ecs_idx_in(eidx), .ecs_low_in(elow), .ecs_to_f_in(ef),
		.port_a_out_cell_out(pa), .port_b_out_cell_out(pb), .ext_chip_sel_c_out(ec), .ext_chip_sel_f_out(ef_o));
	pldm_host_model u_host (.clk_in(clk_in), .host_wr_n_out(wr_n), .host_data_out(dat),
		.host_target_out(tgt), .host_rd_sel_out(rsel), .host_rd_data_in(rdd));
	// ============================================================
	// Compare and verdict
	task automatic chk(input logic [19:0] g, input logic [19:0] e);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Pin inputs cross a synchroniser, so give them a few edges
	task automatic settle();
		repeat (6) @(posedge clk_in);
		@(negedge clk_in);
	endtask
	// Watchdog so a stuck host handshake still ends the run
	initial begin
		repeat (5000) @(posedge clk_in);
		fail_count++;
		give_verdict();
	end
	// ============================================================
	// Main sequence
	initial begin
		{be, sep, pm, lclk, fr, pd, addr, ctl, page, pa_i, pb_i, pc_i} = '0;
		{dt, dc, gt, gc, ss} = '0;
		// Enum cells set one by one so no plain vector lands in an enum
		foreach (ty[n]) ty[n] = FF_D;
		{kidx, cidx, pidx, clr, eidx} = '1;
		{inv, regs, cpin, elow, ef} = {16'h0001, 16'hFFFE, 16'hFFFF, 8'h02, 8'h02};
		// Decode terms on address and control bits, general terms on cells, pins and page
		{dt[0][15], dt[24][14], dt[36][13], dt[39][12], dt[40][16], dt[41][11]} = 6'h3F;
		{gt[0][0], gt[1][8], gt[2][16], gt[3][40], gt[4][41]} = 5'h1F;
		{ss[0][0], ss[8][1], ss[10][4]} = 3'h7;
		ty[10] = FF_T;
		ty[11] = FF_JK;
		ty[12] = FF_SR;
		{clr[9][0], clr[1][1], eidx[0], eidx[1]} = {8'h02, 8'h02, 8'h03, 8'h03};
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		repeat (5) @(posedge clk_in);
		u_host.rd(RD_MASK, q);
		chk(q, 16'h0000);
		// Combined and separate space, peripheral gate on and off
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_in);
			{sep, pm, addr, ctl} <= {i >= 2, i != 1, ad[i], 3'h1};
			repeat (2) @(posedge clk_in);
			@(negedge clk_in);
			chk({3'h0, pri, sec, sram, cfg, tst, per}, ex[i]);
		end
		// External chip selects: one active high on C, one active low on F
		chk({4'h0, ec, ef_o}, 20'h00202);
		@(posedge clk_in);
		page <= 8'h01;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		chk({4'h0, ec, ef_o}, 20'h00300);
		// Host loads in both lane orders; cell 0 is combinational and inverted
		u_host.wr(16'hA55A, TGT_OMC);
		chk({pb, pa}, 16'hA55B);
		u_host.rd(RD_OMC, q);
		chk(q, 16'hA55A);
		@(posedge clk_in);
		be <= 1'b1;
		u_host.wr(16'h1234, TGT_OMC);
		chk({pb, pa}, 16'h3413);
		@(posedge clk_in);
		be <= 1'b0;
		// Mask blocks loads to the low nibble of port A
		u_host.wr(16'h000F, TGT_MASK_A);
		u_host.rd(RD_MASK, q);
		chk(q, 16'h000F);
		u_host.wr(16'hFFFF, TGT_OMC);
		chk({pb, pa}, 16'hFFF3);
		@(posedge clk_in);
		pa_i <= 8'h01;
		settle();
		chk({pb, pa}, 16'hFFF2);
		u_host.rd(RD_OMC, q);
		chk(q, 16'hFFF2);
		// Pin clock: D cells take their sum, T, JK and SR hold
		@(posedge clk_in);
		pb_i <= 8'h01;
		settle();
		@(posedge clk_in);
		lclk <= 1'b1;
		settle();
		chk({pb, pa}, 16'h1D00);
		// One clear term pulls cell 9 low on its first clear input and cell 1 on its second
		u_host.wr(16'h0000, TGT_MASK_A);
		u_host.wr(16'hFFFF, TGT_OMC);
		chk({pb, pa}, 16'hFFFE);
		@(posedge clk_in);
		pc_i <= 8'h01;
		settle();
		chk({pb, pa}, 16'hFDFC);
		u_host.rd(RD_IMC_AB, q);
		chk(q, 16'h0101);
		u_host.rd(RD_IMC_C, q);
		chk(q, 16'h0001);
		give_verdict();
	end
endmodule
`default_nettype wire
